// file: core/rdct_defines.svh
`ifndef RDCT_DEFINES_SVH
`define RDCT_DEFINES_SVH

// ====================================================
// Register indices (byte address = 4 * index)
`define RDCT_IDX_FLAG 12'hF02
`define RDCT_IDX_ENABLE 12'hF12
`define RDCT_IDX_CNT_LO 12'hF24
`define RDCT_IDX_CNT_HI 12'hF25
`define RDCT_IDX_RLD_LO 12'hF26
`define RDCT_IDX_RLD_HI 12'hF27
`define RDCT_IDX_CTRL 12'hF78
`define RDCT_IDX_SRC 12'hF79

// ====================================================
// Field positions
`define RDCT_BIT_RUN 0
`define RDCT_BIT_RELOAD 1
`define RDCT_BIT_IRQ 0
`define RDCT_BIT_OUT_EN 3

// ====================================================
// Reset values
`define RDCT_SRC_RESET 4'h0
`define RDCT_RUN_RESET 1'h0

// ====================================================
// Timing
`define RDCT_CLK_HZ 10000000
`define RDCT_BASE_HZ 16384
`define RDCT_BASE_DIV (`RDCT_CLK_HZ / `RDCT_BASE_HZ)
`define RDCT_REJECT_MS 2
`define RDCT_ACCEPT_MS 4
`define RDCT_FILT_CYCLES (((`RDCT_REJECT_MS + `RDCT_ACCEPT_MS) * (`RDCT_CLK_HZ / 1000)) / 2)

`endif

// file: core/rdct_pkg.sv
// ====================================================
// Shared types of the reload down counter timer
package rdct_pkg;

  // Count source selection codes
  typedef enum logic [2:0] {
    SRC_EXT_FILT = 3'h0,
    SRC_EXT_DIRECT = 3'h1,
    SRC_256HZ = 3'h2,
    SRC_512HZ = 3'h3,
    SRC_1024HZ = 3'h4,
    SRC_2048HZ = 3'h5,
    SRC_4096HZ = 3'h6,
    SRC_8192HZ = 3'h7
  } rdct_src_t;

  // Bus answer state; the code doubles as waitrequest
  typedef enum logic {
    BUS_ANSWER = 1'h0,
    BUS_WAIT = 1'h1
  } rdct_bus_t;

  // Source select and output enable register
  typedef struct packed {
    logic sourceOutputEnable;
    rdct_src_t countSourceSelect;
  } rdct_srcsel_t;

endpackage

// file: core/rdct_timer.sv
// Function
// - Three-bit select picks one of eight sources
// - Output enable drives selected source to pin
// - Reload value held in two nibble registers
// - Reload on reload command or zero count
// - Reload zero divides by 256
// - Reload and count undefined after reset
// - Reload command bit writes one, reads zero
// - Reload while running resumes; stopped holds value
// - Run bit enables counting, resets to zero
// - Stopped counter keeps its value
// - Count nibbles are read-only
// - Interrupt enable bit, reset masked
// - Flag sets at zero regardless of enable
// - Decrement on falling source edge while running
// - Filtered input rejects 2 ms, accepts 4 ms
`timescale 1ns/100ps
`default_nettype none
`include "rdct_defines.svh"

module rdct_timer #(
  parameter int BASE_DIV = `RDCT_BASE_DIV,
  parameter int FILT_CYCLES = `RDCT_FILT_CYCLES
) (
  input wire logic clk, // 10 MHz clock
  input wire logic rst_b, // Synchronous reset, active low
  input wire logic [13:0] avs_address, // Byte address
  input wire logic avs_read, // Read request
  input wire logic avs_write, // Write request
  input wire logic [3:0] avs_byteenable, // Byte lanes
  input wire logic [31:0] avs_writedata, // Write data
  output logic [31:0] avs_readdata, // Read data
  output logic avs_waitrequest, // Stall, low for one answer cycle
  input wire logic extCountIn, // External count input
  output logic srcOutPin, // Selected source out
  output logic timerIrq // Interrupt request, level
);
  import rdct_pkg::*;

  localparam int PRE_W = $clog2(BASE_DIV + 1);
  localparam int FILT_W = $clog2(FILT_CYCLES + 1);

  // ====================================================
  // Bus slave
  rdct_bus_t busState_reg; // Answer state, is waitrequest
  rdct_bus_t busState_next;
  logic [31:0] readData_reg; // Captured read data
  logic [31:0] readData_next;
  logic [11:0] regIdx; // Register index
  logic accept; // Request taken this edge
  logic accWrite; // Write taken, low lane enabled
  logic accRead; // Read captured this edge

  assign regIdx = avs_address[13:2];
  assign accept = (busState_reg == BUS_ANSWER) && (avs_read || avs_write);
  assign accWrite = accept && avs_write && avs_byteenable[0];
  assign accRead = (busState_reg == BUS_WAIT) && avs_read;

  // ====================================================
  // Register state
  rdct_srcsel_t srcSel_reg; // Source select and output enable
  rdct_srcsel_t srcSel_next;
  logic run_reg; // Run control
  logic run_next;
  logic irqEn_reg; // Interrupt enable bit
  logic irqEn_next;
  logic irqFlag_reg; // Interrupt flag bit
  logic irqFlag_next;
  logic [7:0] reload_reg; // Reload value, no reset
  logic [7:0] reload_next;
  logic [7:0] count_reg; // Down counter, no reset
  logic [7:0] count_next;
  logic reloadCmd; // Reload command write
  logic zeroEvent; // Counter reached zero

  // ====================================================
  // Rate generator and source selection
  logic [PRE_W-1:0] pre_reg; // Prescaler to 16384 Hz ticks
  logic [PRE_W-1:0] pre_next;
  logic [5:0] div_reg; // Bit 0 is 8192 Hz, bit 5 is 256 Hz
  logic [5:0] div_next;
  logic srcLevel; // Selected source level
  logic srcPrev_reg; // Previous source level
  logic srcFall; // Falling edge of source
  logic srcOut_reg; // Output pin flop
  logic srcOut_next;
  logic irq_reg; // Interrupt flop
  logic irq_next;

  // ====================================================
  // Noise filter
  logic [FILT_W-1:0] stable_reg; // Cycles input stood unchanged
  logic [FILT_W-1:0] stable_next;
  logic extPrev_reg; // Previous input level
  logic filt_reg; // Filtered input level
  logic filt_next;

  // Bus state and read data next values
  always_comb begin
    busState_next = busState_reg;
    readData_next = readData_reg;
    case (busState_reg)
      BUS_WAIT: begin
        // Capture read data and open answer cycle
        if (avs_read || avs_write) begin
          busState_next = BUS_ANSWER;
          readData_next = 32'h0000_0000;
          case (regIdx)
            `RDCT_IDX_FLAG: readData_next[`RDCT_BIT_IRQ] = irqFlag_reg;
            `RDCT_IDX_ENABLE: readData_next[`RDCT_BIT_IRQ] = irqEn_reg;
            `RDCT_IDX_CNT_LO: readData_next[3:0] = count_reg[3:0];
            `RDCT_IDX_CNT_HI: readData_next[3:0] = count_reg[7:4];
            `RDCT_IDX_RLD_LO: readData_next[3:0] = reload_reg[3:0];
            `RDCT_IDX_RLD_HI: readData_next[3:0] = reload_reg[7:4];
            `RDCT_IDX_CTRL: readData_next[`RDCT_BIT_RUN] = run_reg;
            `RDCT_IDX_SRC: readData_next[3:0] = srcSel_reg;
            default: readData_next = 32'h0000_0000; // Unmapped reads zero
          endcase
        end
      end
      BUS_ANSWER: begin
        // One answer cycle, then stall again
        busState_next = BUS_WAIT;
      end
      default: busState_next = BUS_WAIT;
    endcase
  end

  // Bus state and read data registers
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      busState_reg <= BUS_WAIT;
      readData_reg <= 32'h0000_0000;
    end else begin
      busState_reg <= busState_next;
      readData_reg <= readData_next;
    end
  end

  assign avs_waitrequest = busState_reg;
  assign avs_readdata = readData_reg;

  // Control register next values
  always_comb begin
    srcSel_next = srcSel_reg;
    run_next = run_reg;
    irqEn_next = irqEn_reg;
    reloadCmd = 1'b0;
    if (accWrite) begin
      case (regIdx)
        `RDCT_IDX_ENABLE: irqEn_next = avs_writedata[`RDCT_BIT_IRQ];
        `RDCT_IDX_CTRL: begin
          run_next = avs_writedata[`RDCT_BIT_RUN];
          reloadCmd = avs_writedata[`RDCT_BIT_RELOAD];
        end
        `RDCT_IDX_SRC: srcSel_next = rdct_srcsel_t'(avs_writedata[3:0]);
        default: begin
          // Flag, count and unused bits ignore writes
        end
      endcase
    end
  end

  // Control registers
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      srcSel_reg <= rdct_srcsel_t'(`RDCT_SRC_RESET);
      run_reg <= `RDCT_RUN_RESET;
      irqEn_reg <= 1'b0;
    end else begin
      srcSel_reg <= srcSel_next;
      run_reg <= run_next;
      irqEn_reg <= irqEn_next;
    end
  end

  // Rate generator next values
  always_comb begin
    pre_next = pre_reg + PRE_W'(1);
    div_next = div_reg;
    if (pre_reg == PRE_W'(BASE_DIV - 1)) begin
      pre_next = '0;
      div_next = div_reg + 6'h01;
    end
  end

  // Source selection
  always_comb begin
    case (srcSel_reg.countSourceSelect)
      SRC_EXT_FILT: srcLevel = filt_reg;
      SRC_EXT_DIRECT: srcLevel = extCountIn;
      SRC_256HZ: srcLevel = div_reg[5];
      SRC_512HZ: srcLevel = div_reg[4];
      SRC_1024HZ: srcLevel = div_reg[3];
      SRC_2048HZ: srcLevel = div_reg[2];
      SRC_4096HZ: srcLevel = div_reg[1];
      SRC_8192HZ: srcLevel = div_reg[0];
      default: srcLevel = 1'b0;
    endcase
  end

  assign srcFall = srcPrev_reg && !srcLevel;
  assign srcOut_next = srcSel_reg.sourceOutputEnable && srcLevel;
  assign irq_next = irqFlag_reg && irqEn_reg;

  // Rate generator, edge history and output flops
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pre_reg <= '0;
      div_reg <= 6'h00;
      srcPrev_reg <= 1'b0;
      srcOut_reg <= 1'b0;
      irq_reg <= 1'b0;
    end else begin
      pre_reg <= pre_next;
      div_reg <= div_next;
      srcPrev_reg <= srcLevel;
      srcOut_reg <= srcOut_next;
      irq_reg <= irq_next;
    end
  end

  assign srcOutPin = srcOut_reg;
  assign timerIrq = irq_reg;

  // Noise filter: follows input only after it stood long enough
  always_comb begin
    filt_next = filt_reg;
    stable_next = stable_reg;
    if (extCountIn != extPrev_reg) begin
      stable_next = '0;
    end else if (stable_reg != FILT_W'(FILT_CYCLES)) begin
      stable_next = stable_reg + FILT_W'(1);
    end else begin
      filt_next = extCountIn;
    end
  end

  // Noise filter registers
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      stable_reg <= '0;
      extPrev_reg <= 1'b0;
      filt_reg <= 1'b0;
    end else begin
      stable_reg <= stable_next;
      extPrev_reg <= extCountIn;
      filt_reg <= filt_next;
    end
  end

  // Counter, reload value and flag next values
  always_comb begin
    reload_next = reload_reg;
    count_next = count_reg;
    irqFlag_next = irqFlag_reg;
    zeroEvent = 1'b0;
    if (accWrite && regIdx == `RDCT_IDX_RLD_LO) begin
      reload_next[3:0] = avs_writedata[3:0];
    end
    if (accWrite && regIdx == `RDCT_IDX_RLD_HI) begin
      reload_next[7:4] = avs_writedata[3:0];
    end
    if (reloadCmd) begin
      count_next = reload_reg;
    end else if (run_reg && srcFall) begin
      // Decrement; reaching zero reloads, so zero reload wraps 256
      if (count_reg == 8'h01) begin
        count_next = reload_reg;
        zeroEvent = 1'b1;
      end else begin
        count_next = count_reg - 8'h01;
      end
    end
    // Read clears at the capture edge, so no set can slip in unseen
    // between capture and clear; a zero event in the same cycle wins
    if (accRead && regIdx == `RDCT_IDX_FLAG) begin
      irqFlag_next = 1'b0;
    end
    if (zeroEvent) begin
      irqFlag_next = 1'b1;
    end
  end

  // Flag register
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      irqFlag_reg <= 1'b0;
    end else begin
      irqFlag_reg <= irqFlag_next;
    end
  end

  // Counter and reload data, left unreset
  always_ff @(posedge clk) begin
    reload_reg <= reload_next;
    count_reg <= count_next;
  end

  // ====================================================
  // Assertions
  default clocking rdctCb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  sequence reloadWriteSeq;
    accWrite && regIdx == `RDCT_IDX_CTRL && avs_writedata[`RDCT_BIT_RELOAD];
  endsequence

  sequence countTickSeq;
    run_reg && srcFall && !reloadCmd;
  endsequence

  reload_cmd_a: assert property (reloadWriteSeq |=> count_reg == $past(reload_reg))
    else $error("Reload command did not load counter");
  flag_set_a: assert property (countTickSeq ##0 count_reg == 8'h01 |=> irqFlag_reg && count_reg == $past(reload_reg))
    else $error("Zero count did not set flag and reload");
  wrap_zero_a: assert property (countTickSeq ##0 count_reg == 8'h00 |=> count_reg == 8'hFF)
    else $error("Zero reload did not wrap");
  count_dec_a: assert property (countTickSeq ##0 count_reg > 8'h01 |=> count_reg == $past(count_reg) - 8'h01)
    else $error("Counter did not decrement");
  stop_hold_a: assert property (!run_reg && !reloadCmd |=> $stable(count_reg))
    else $error("Stopped counter changed");
  irq_level_a: assert property (irqFlag_reg && irqEn_reg |=> timerIrq)
    else $error("Interrupt request missing while flag and enable set");
  irq_quiet_a: assert property (!(irqFlag_reg && irqEn_reg) |=> !timerIrq)
    else $error("Interrupt request raised without flag and enable");
  out_pin_a: assert property (!srcSel_reg.sourceOutputEnable |=> !srcOutPin)
    else $error("Source output driven while disabled");
  ctrl_read_a: assert property (!avs_waitrequest && avs_read && regIdx == `RDCT_IDX_CTRL
    |-> avs_readdata[31:1] == 31'h0000_0000)
    else $error("Control read shows reload bit or unused bits");
  enable_write_a: assert property (accWrite && regIdx == `RDCT_IDX_ENABLE
    |=> irqEn_reg == $past(avs_writedata[`RDCT_BIT_IRQ]) ##1 $stable(irqEn_reg))
    else $error("Enable bit write not kept");
  filt_change_a: assert property ($changed(filt_reg) |-> $past(stable_reg) == FILT_W'(FILT_CYCLES))
    else $error("Filter changed before input stood long enough");
  direct_src_a: assert property (srcSel_reg.sourceOutputEnable && srcSel_reg.countSourceSelect == SRC_EXT_DIRECT
    |=> srcOutPin == $past(extCountIn))
    else $error("Direct source does not reach the output pin");
  run_write_a: assert property (accWrite && regIdx == `RDCT_IDX_CTRL |=> run_reg == $past(avs_writedata[0]))
    else $error("Run bit write lost");
  count_ro_a: assert property (accWrite && regIdx == `RDCT_IDX_CNT_LO && !reloadCmd && !(run_reg && srcFall)
    |=> $stable(count_reg))
    else $error("Write changed count");

endmodule // rdct_timer

`default_nettype wire

// file: test/rdct_timer_tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "rdct_defines.svh"

module rdct_timer_tb;
  import rdct_pkg::*;
  // ==================================================
  // Bench signals
  localparam int BDIV = 2; // Short tick divider for sim
  localparam int FILT = 4; // Short filter span
  logic clk = 1'h0; // 10 MHz clock
  logic rst_b = 1'h0; // Reset, active low
  logic [13:0] avs_address = 14'h0; // Byte address
  logic avs_read = 1'h0; // Read strobe
  logic avs_write = 1'h0; // Write strobe
  logic [3:0] avs_byteenable = 4'hF; // All lanes on
  logic [31:0] avs_writedata = 32'h0; // Write data
  logic [31:0] avs_readdata; // Read data
  logic avs_waitrequest; // Stall
  logic extCountIn = 1'h1; // External input idles high
  logic srcOutPin; // Selected source out
  logic timerIrq; // Interrupt request
  int badCount = 0; // Mismatches
  int compares = 0; // Checks made

  rdct_timer #(.BASE_DIV(BDIV), .FILT_CYCLES(FILT)) u_rdct_timer (
    .clk(clk), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .extCountIn(extCountIn), .srcOutPin(srcOutPin), .timerIrq(timerIrq)
  );

  // Half period of 50 ns
  always #50 clk = ~clk;

  // ==================================================
  // Verdict and compares
  task automatic print_verdict();
    if (badCount == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk_nib(input string nm, input logic [3:0] e, input logic [3:0] g);
    compares++;
    if (g !== e) begin
      badCount++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_int(input string nm, input int e, input int g);
    compares++;
    if (g != e) begin
      badCount++;
      $display("Error %s expected %0d seen %0d", nm, e, g);
    end
  endtask

  // ==================================================
  // Bus master: hold request until waitrequest seen low
  task automatic bus(input logic [11:0] idx, input logic w, input logic [3:0] wd, output logic [3:0] rd);
    avs_address <= {idx, 2'h0};
    avs_writedata <= {28'h0, wd};
    avs_write <= w;
    avs_read <= !w;
    // Only the watchdog ends a wait for an answer that never comes
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'h0);
    rd = avs_readdata[3:0];
    avs_write <= 1'h0;
    avs_read <= 1'h0;
    // Idle edge so the next request starts cleanly
    @(posedge clk);
  endtask

  task automatic wr(input logic [11:0] idx, input logic [3:0] d);
    logic [3:0] x;
    bus(idx, 1'h1, d, x);
  endtask

  task automatic rd_chk(input string nm, input logic [11:0] idx, input logic [3:0] e);
    logic [3:0] v;
    bus(idx, 1'h0, 4'h0, v);
    chk_nib(nm, e, v);
  endtask

  task automatic rd_cnt(input logic [7:0] e);
    rd_chk("cntLo", `RDCT_IDX_CNT_LO, e[3:0]);
    rd_chk("cntHi", `RDCT_IDX_CNT_HI, e[7:4]);
  endtask

  // Pulses low on the external input, w cycles low then w high
  task automatic pulse(input int n, input int w);
    repeat (n) begin
      extCountIn <= 1'h0;
      repeat (w) @(posedge clk);
      extCountIn <= 1'h1;
      repeat (w) @(posedge clk);
    end
  endtask

  task automatic set_reload(input logic [7:0] v, input logic [3:0] ctl);
    wr(`RDCT_IDX_RLD_LO, v[3:0]);
    wr(`RDCT_IDX_RLD_HI, v[7:4]);
    wr(`RDCT_IDX_CTRL, ctl);
  endtask

  // ==================================================
  // Scenarios
  task automatic t_reset();
    rd_chk("flag", `RDCT_IDX_FLAG, 4'h0);
    rd_chk("enable", `RDCT_IDX_ENABLE, 4'h0);
    rd_chk("ctrl", `RDCT_IDX_CTRL, 4'h0);
    rd_chk("src", `RDCT_IDX_SRC, 4'h0);
    chk_nib("irq", 4'h0, {3'h0, timerIrq});
    chk_nib("outPin", 4'h0, {3'h0, srcOutPin});
  endtask

  task automatic t_regs();
    set_reload(8'hA5, 4'h2);
    rd_chk("rldLo", `RDCT_IDX_RLD_LO, 4'h5);
    rd_chk("rldHi", `RDCT_IDX_RLD_HI, 4'hA);
    rd_chk("ctrl", `RDCT_IDX_CTRL, 4'h0);
    rd_cnt(8'hA5);
    wr(`RDCT_IDX_CNT_LO, 4'h0);
    wr(`RDCT_IDX_CNT_HI, 4'h0);
    rd_cnt(8'hA5);
    wr(`RDCT_IDX_FLAG, 4'hF);
    rd_chk("flag", `RDCT_IDX_FLAG, 4'h0);
    wr(`RDCT_IDX_ENABLE, 4'hF);
    rd_chk("enable", `RDCT_IDX_ENABLE, 4'h1);
    wr(`RDCT_IDX_ENABLE, 4'h0);
    // Write with the low lane off is answered but ignored
    avs_byteenable <= 4'hE;
    wr(`RDCT_IDX_ENABLE, 4'h1);
    avs_byteenable <= 4'hF;
    rd_chk("laneOff", `RDCT_IDX_ENABLE, 4'h0);
    wr(12'h100, 4'hF);
    rd_chk("unmapped", 12'h100, 4'h0);
    wr(`RDCT_IDX_SRC, 4'hF);
    rd_chk("src", `RDCT_IDX_SRC, 4'hF);
  endtask

  task automatic t_count();
    wr(`RDCT_IDX_SRC, {1'h1, SRC_EXT_DIRECT});
    set_reload(8'h03, 4'h2);
    wr(`RDCT_IDX_CTRL, 4'h1);
    pulse(1, 3);
    rd_cnt(8'h02);
    pulse(1, 3);
    rd_cnt(8'h01);
    rd_chk("flag", `RDCT_IDX_FLAG, 4'h0);
    pulse(1, 3);
    rd_cnt(8'h03);
    chk_nib("irq", 4'h0, {3'h0, timerIrq});
    wr(`RDCT_IDX_ENABLE, 4'h1);
    repeat (2) @(posedge clk);
    chk_nib("irq", 4'h1, {3'h0, timerIrq});
    rd_chk("flag", `RDCT_IDX_FLAG, 4'h1);
    rd_chk("flag", `RDCT_IDX_FLAG, 4'h0);
    repeat (2) @(posedge clk);
    chk_nib("irq", 4'h0, {3'h0, timerIrq});
    wr(`RDCT_IDX_ENABLE, 4'h0);
    // Stopped counter ignores edges and keeps its value
    wr(`RDCT_IDX_CTRL, 4'h0);
    pulse(2, 3);
    rd_cnt(8'h03);
    set_reload(8'h07, 4'h2);
    pulse(1, 3);
    rd_cnt(8'h07);
    wr(`RDCT_IDX_CTRL, 4'h1);
    pulse(1, 3);
    rd_cnt(8'h06);
    wr(`RDCT_IDX_CTRL, 4'h3);
    pulse(1, 3);
    rd_cnt(8'h06);
    // Stop, read both halves, then restart
    wr(`RDCT_IDX_CTRL, 4'h0);
    rd_cnt(8'h06);
    wr(`RDCT_IDX_CTRL, 4'h1);
    rd_chk("ctrl", `RDCT_IDX_CTRL, 4'h1);
  endtask

  task automatic t_wrap();
    set_reload(8'h00, 4'h3);
    rd_cnt(8'h00);
    pulse(255, 3);
    rd_cnt(8'h01);
    rd_chk("flag", `RDCT_IDX_FLAG, 4'h0);
    pulse(1, 3);
    rd_chk("flag", `RDCT_IDX_FLAG, 4'h1);
    rd_cnt(8'h00);
  endtask

  task automatic t_filter();
    wr(`RDCT_IDX_SRC, {1'h0, SRC_EXT_FILT});
    repeat (2 * FILT) @(posedge clk);
    set_reload(8'h05, 4'h3);
    pulse(1, FILT / 2);
    rd_cnt(8'h05);
    pulse(1, 2 * FILT);
    rd_cnt(8'h04);
  endtask

  // Falling-edge spacing on the output pin for each internal rate
  task automatic t_rates();
    int n, f1, f2;
    logic prev;
    for (int c = 2; c < 8; c++) begin
      wr(`RDCT_IDX_SRC, {1'h1, 3'(c)});
      repeat (4) @(posedge clk);
      f1 = -1;
      f2 = -1;
      prev = srcOutPin;
      for (n = 0; n < 600 && f2 < 0; n++) begin
        @(posedge clk);
        if (prev === 1'h1 && srcOutPin === 1'h0) begin
          if (f1 < 0) f1 = n;
          else f2 = n;
        end
        prev = srcOutPin;
      end
      chk_int("srcPeriod", BDIV * (64 >> (c - 2)), f2 - f1);
    end
    // Output disabled keeps the pin low
    wr(`RDCT_IDX_SRC, 4'h7);
    repeat (16) begin
      @(posedge clk);
      chk_nib("outPin", 4'h0, {3'h0, srcOutPin});
    end
  endtask

  // ==================================================
  // Main sequence
  initial begin
    repeat (6) @(posedge clk);
    rst_b <= 1'h1;
    @(posedge clk);
    t_reset();
    t_regs();
    t_count();
    t_wrap();
    t_filter();
    t_rates();
    print_verdict();
  end

  // Watchdog well beyond the expected few thousand cycles
  initial begin
    repeat (20000) @(posedge clk);
    badCount++;
    print_verdict();
  end
endmodule // rdct_timer_tb

`default_nettype wire
